// File: hdl/adapter_status_led_driver.sv
`timescale 1ns/1ps
`include "led_regs.svh"

// Overview of operation
// RULE1: Operational: module LED steady green
// RULE2: Unconfigured: module LED flashes green
// RULE3: Self-test module LED: green, red, green hold
// RULE4: Self-test network LED: green, red, dark
// RULE5: Recoverable fault: module LED flashes red
// RULE6: Unrecoverable fault: module LED steady red
// RULE7: IP and connection: network LED green
// RULE8: IP, no connection: network LED flashes green
// RULE9: Owner connection timeout: network LED flashes red
// RULE10: Green again only when timeout cleared
// RULE11: Duplicate IP: network LED steady red
// RULE12: No IP: network LED dark
// RULE13: Link LED follows Ethernet link
// RULE14: Traffic LED flickers with frames, else dark
// RULE15: Flashing is 500 ms on, 500 off
// RULE16: Flicker 50 ms on/off, follows sparse events
// RULE17: Fixed priority among module and network states
// RULE18: All timing from one divided ms tick
module adapter_status_led_driver
    import led_pkg::*;
#(
    parameter int CLK_PER_MS = `CLK_PER_MS
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic phy_link,
    input wire logic phy_activity,
    output logic module_state_led_green,
    output logic module_state_led_red,
    output logic network_state_led_green,
    output logic network_state_led_red,
    output logic link_led,
    output logic traffic_led
);

    state_t s_q;
    state_t s_d;
    logic ms_tick;
    logic act_event;
    logic run;

    // Single millisecond timebase
    ms_tick_divider #(
        .CLK_PER_MS(CLK_PER_MS)
    ) u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .ms_tick(ms_tick)
    ); // RULE18

    assign act_event = s_q.act_sync[1] & ~s_q.act_sync[2];
    assign run = (s_q.st == ST_RUN);

    always_comb
    begin
        s_d = s_q;

        // Pin synchronisers; activity gets a third stage for the edge
        s_d.lnk_sync = {s_q.lnk_sync[0], phy_link};
        s_d.act_sync = {s_q.act_sync[1:0], phy_activity};

        if (wr_en && addr == `CTRL_OFS)
        begin
            s_d.ctrl = ctrl_t'(wr_data);
        end

        s_d.rd_data = 8'h00;
        if (rd_en)
        begin
            if (addr == `CTRL_OFS)
            begin
                s_d.rd_data = s_q.ctrl;
            end
            else if (addr == `STAT_OFS)
            begin
                s_d.rd_data = {1'b0, run, s_q.leds};
            end
        end

        // Power-on self-test sequence
        if (ms_tick && s_q.st != ST_HOLD && s_q.st != ST_RUN)
        begin
            s_d.st_cnt = s_q.st_cnt + 10'h001;
        end
        unique case (s_q.st)
            ST_GREEN:
            begin
                if (ms_tick && s_q.st_cnt == 10'(`SELFTEST_PHASE_TICKS - 1))
                begin
                    s_d.st = ST_RED; // RULE3 RULE4
                    s_d.st_cnt = 10'h000;
                end
            end
            ST_RED:
            begin
                if (ms_tick && s_q.st_cnt == 10'(`SELFTEST_PHASE_TICKS - 1))
                begin
                    s_d.st = ST_HOLD; // RULE3 RULE4
                    s_d.st_cnt = 10'h000;
                end
            end
            ST_HOLD:
            begin
                if (s_q.ctrl.selftest_done)
                begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                s_d.st = ST_RUN;
            end
        endcase

        // 1 Hz flash phase
        if (ms_tick)
        begin
            if (s_q.fl_cnt == 10'(`FLASH_HALF_TICKS - 1))
            begin
                s_d.fl_cnt = 10'h000;
                s_d.flash_on = ~s_q.flash_on; // RULE15
            end
            else
            begin
                s_d.fl_cnt = s_q.fl_cnt + 10'h001;
            end
        end

        // Traffic flicker: lit half, dark half, repeat while events pend
        if (act_event && (s_q.ak_lit || s_q.ak_gap))
        begin
            s_d.ak_pend = 1'b1;
        end
        if (!s_q.ak_lit && !s_q.ak_gap)
        begin
            if (act_event)
            begin
                s_d.ak_lit = 1'b1; // RULE14
                s_d.ak_cnt = 10'h000;
            end
        end
        else if (ms_tick)
        begin
            if (s_q.ak_cnt == 10'(`FLICKER_HALF_TICKS - 1))
            begin
                s_d.ak_cnt = 10'h000;
                if (s_q.ak_lit)
                begin
                    s_d.ak_lit = 1'b0; // RULE16
                    s_d.ak_gap = 1'b1;
                end
                else
                begin
                    // A frame edge in this very cycle still counts
                    s_d.ak_gap = 1'b0;
                    s_d.ak_lit = s_q.ak_pend | act_event; // RULE16
                    s_d.ak_pend = 1'b0;
                end
            end
            else
            begin
                s_d.ak_cnt = s_q.ak_cnt + 10'h001;
            end
        end

        // Module status, highest priority first
        s_d.leds.ms_green = 1'b0;
        s_d.leds.ms_red = 1'b0;
        if (s_q.st == ST_RED)
        begin
            s_d.leds.ms_red = 1'b1; // RULE3 RULE17
        end
        else if (!run)
        begin
            s_d.leds.ms_green = 1'b1; // RULE3
        end
        else if (s_q.ctrl.fault_unrec)
        begin
            s_d.leds.ms_red = 1'b1; // RULE6 RULE17
        end
        else if (s_q.ctrl.fault_rec)
        begin
            s_d.leds.ms_red = s_q.flash_on; // RULE5
        end
        else if (!s_q.ctrl.configured)
        begin
            s_d.leds.ms_green = s_q.flash_on; // RULE2
        end
        else
        begin
            s_d.leds.ms_green = 1'b1; // RULE1
        end

        // Network status
        s_d.leds.ns_green = 1'b0;
        s_d.leds.ns_red = 1'b0;
        if (s_q.st == ST_GREEN)
        begin
            s_d.leds.ns_green = 1'b1; // RULE4
        end
        else if (s_q.st == ST_RED)
        begin
            s_d.leds.ns_red = 1'b1; // RULE4
        end
        else if (!run)
        begin
            s_d.leds.ns_green = 1'b0; // RULE4
        end
        else if (s_q.ctrl.dup_ip)
        begin
            s_d.leds.ns_red = 1'b1; // RULE11 RULE17
        end
        else if (!s_q.ctrl.ip_set)
        begin
            s_d.leds.ns_red = 1'b0; // RULE12
        end
        else if (s_q.ctrl.eo_timeout)
        begin
            s_d.leds.ns_red = s_q.flash_on; // RULE9 RULE10
        end
        else if (s_q.ctrl.conn_up)
        begin
            s_d.leds.ns_green = 1'b1; // RULE7
        end
        else
        begin
            s_d.leds.ns_green = s_q.flash_on; // RULE8
        end

        s_d.leds.link = s_q.lnk_sync[1]; // RULE13
        s_d.leds.traffic = s_q.ak_lit; // RULE14
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.ctrl <= `CTRL_RST;
            s_q.st <= ST_GREEN;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd_data;
    assign module_state_led_green = s_q.leds.ms_green;
    assign module_state_led_red = s_q.leds.ms_red;
    assign network_state_led_green = s_q.leds.ns_green;
    assign network_state_led_red = s_q.leds.ns_red;
    assign link_led = s_q.leds.link;
    assign traffic_led = s_q.leds.traffic;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence green_phase_end;
        s_q.st == ST_GREEN && ms_tick && s_q.st_cnt == 10'(`SELFTEST_PHASE_TICKS - 1);
    endsequence

    sequence red_phase_end;
        s_q.st == ST_RED && ms_tick && s_q.st_cnt == 10'(`SELFTEST_PHASE_TICKS - 1);
    endsequence

    selftest_red_a: assert property (green_phase_end |=> s_q.st == ST_RED ##1
        (module_state_led_red && !module_state_led_green && network_state_led_red)) // RULE3
        else $error("self-test red phase not shown");
    selftest_hold_a: assert property (red_phase_end |=> ##1
        (module_state_led_green && !network_state_led_green && !network_state_led_red)) // RULE4
        else $error("self-test hold pattern wrong");
    ms_operational_a: assert property (run && s_q.ctrl.configured && !s_q.ctrl.fault_rec
        && !s_q.ctrl.fault_unrec |=> module_state_led_green && !module_state_led_red) // RULE1
        else $error("module LED not steady green");
    ms_standby_a: assert property (run && !s_q.ctrl.configured && !s_q.ctrl.fault_rec
        && !s_q.ctrl.fault_unrec |=> module_state_led_green == $past(s_q.flash_on)) // RULE2
        else $error("module LED not flashing green");
    ms_recov_a: assert property (run && s_q.ctrl.fault_rec && !s_q.ctrl.fault_unrec
        |=> module_state_led_red == $past(s_q.flash_on) && !module_state_led_green) // RULE5
        else $error("module LED not flashing red");
    ms_unrecov_a: assert property (run && s_q.ctrl.fault_unrec
        |=> module_state_led_red && !module_state_led_green) // RULE6
        else $error("module LED not steady red");
    ns_dup_ip_a: assert property (run && s_q.ctrl.dup_ip
        |=> network_state_led_red && !network_state_led_green) // RULE11
        else $error("duplicate IP not steady red");
    ns_no_ip_a: assert property (run && !s_q.ctrl.dup_ip && !s_q.ctrl.ip_set
        |=> !network_state_led_red && !network_state_led_green) // RULE12
        else $error("network LED lit without IP");
    ns_timeout_a: assert property (run && !s_q.ctrl.dup_ip && s_q.ctrl.ip_set
        && s_q.ctrl.eo_timeout
        |=> network_state_led_red == $past(s_q.flash_on) && !network_state_led_green) // RULE9
        else $error("network LED not flashing red on timeout");
    ns_standby_a: assert property (run && !s_q.ctrl.dup_ip && s_q.ctrl.ip_set
        && !s_q.ctrl.eo_timeout && !s_q.ctrl.conn_up
        |=> network_state_led_green == $past(s_q.flash_on) && !network_state_led_red) // RULE8
        else $error("network LED not flashing green");
    ns_connected_a: assert property (run && !s_q.ctrl.dup_ip && s_q.ctrl.ip_set
        && !s_q.ctrl.eo_timeout && s_q.ctrl.conn_up |=> network_state_led_green) // RULE7
        else $error("network LED not steady green");
    flash_period_a: assert property ($changed(s_q.flash_on)
        |-> $past(ms_tick) && $past(s_q.fl_cnt) == 10'(`FLASH_HALF_TICKS - 1)) // RULE15
        else $error("flash toggled off the 500 ms mark");
    link_follow_a: assert property (phy_link [*3] |=> link_led) // RULE13
        else $error("link LED not following link");
    flicker_end_a: assert property ($fell(s_q.ak_lit)
        |-> $past(ms_tick) && $past(s_q.ak_cnt) == 10'(`FLICKER_HALF_TICKS - 1)) // RULE16
        else $error("flicker lit time wrong");

endmodule

// File: hdl/led_regs.svh
`ifndef LED_REGS_SVH
`define LED_REGS_SVH

// Register offsets on the plain register port
`define CTRL_OFS 4'h0
`define STAT_OFS 4'h4
`define CTRL_RST 8'h00

// System clock and millisecond timebase
`define CLK_HZ 125000000
`define CLK_PER_MS (`CLK_HZ / 1000)
`define TICKS_PER_MS 1

// Pattern times in ms, and their counts in ms ticks
`define SELFTEST_PHASE_MS 250
`define FLASH_HALF_MS 500
`define FLICKER_HALF_MS 50
`define SELFTEST_PHASE_TICKS (`SELFTEST_PHASE_MS * `TICKS_PER_MS)
`define FLASH_HALF_TICKS (`FLASH_HALF_MS * `TICKS_PER_MS)
`define FLICKER_HALF_TICKS (`FLICKER_HALF_MS * `TICKS_PER_MS)

`endif

// File: hdl/led_pkg.sv
package led_pkg;

    typedef struct packed {
        logic dup_ip;
        logic eo_timeout;
        logic conn_up;
        logic ip_set;
        logic fault_unrec;
        logic fault_rec;
        logic configured;
        logic selftest_done;
    } ctrl_t;

    typedef enum logic [3:0] {
        ST_GREEN = 4'b0001,
        ST_RED = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_RUN = 4'b1000
    } stest_t;

    typedef struct packed {
        logic ms_green;
        logic ms_red;
        logic ns_green;
        logic ns_red;
        logic link;
        logic traffic;
    } leds_t;

    typedef struct packed {
        ctrl_t ctrl;
        stest_t st;
        logic [9:0] st_cnt;
        logic [9:0] fl_cnt;
        logic flash_on;
        logic [9:0] ak_cnt;
        logic ak_lit;
        logic ak_gap;
        logic ak_pend;
        logic [1:0] lnk_sync;
        logic [2:0] act_sync;
        leds_t leds;
        logic [7:0] rd_data;
    } state_t;

    typedef struct packed {
        logic [19:0] cnt;
        logic tick;
    } div_t;

endpackage

// File: hdl/ms_tick_divider.sv
`timescale 1ns/1ps
`include "led_regs.svh"

module ms_tick_divider
    import led_pkg::*;
#(
    parameter int CLK_PER_MS = `CLK_PER_MS
)
(
    input wire logic mclk,
    input wire logic rst_n,
    output logic ms_tick
);

    if (CLK_PER_MS < 2 || CLK_PER_MS > 1048576)
    begin : g_bad_ratio
        $error("CLK_PER_MS out of range");
    end

    div_t s_q;
    div_t s_d;

    // One-cycle pulse every CLK_PER_MS cycles
    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 20'(CLK_PER_MS - 1))
        begin
            s_d.cnt = 20'h00000;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 20'h00001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign ms_tick = s_q.tick;

endmodule

// File: dv/led_panel.sv
`timescale 1ns/1ps

// Front-panel lamp: measures how long it stays lit and counts its light-ups
module led_panel
(
    input wire logic mclk,
    input wire logic green,
    input wire logic red,
    output logic [15:0] lit_len,
    output logic [7:0] rises
);
    logic [15:0] run_q = 16'h0000;
    logic was_q = 1'b0;

    initial
    begin
        lit_len = 16'h0000;
        rises = 8'h00;
    end

    always @(posedge mclk)
    begin
        if (green | red)
            run_q <= run_q + 16'h0001;
        else
        begin
            if (was_q)
                lit_len <= run_q;
            run_q <= 16'h0000;
        end
        if ((green | red) && !was_q)
            rises <= rises + 8'h01;
        was_q <= green | red;
    end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import led_pkg::*;
    localparam int CYC_MS = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic phy_link = 1'b0;
    logic phy_activity = 1'b0;
    logic msg, msr, nsg, nsr, link_led, traffic_led;
    logic [15:0] ms_len, ns_len, tr_len;
    logic [7:0] tr_rises;
    int err_total = 0;
    int n_tests = 0;

    always #4 mclk = ~mclk;

    adapter_status_led_driver #(.CLK_PER_MS(CYC_MS)) dut_u (.mclk(mclk), .rst_n(rst_n),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .phy_link(phy_link), .phy_activity(phy_activity), .module_state_led_green(msg),
        .module_state_led_red(msr), .network_state_led_green(nsg),
        .network_state_led_red(nsr), .link_led(link_led), .traffic_led(traffic_led));
    led_panel ms_u (.mclk(mclk), .green(msg), .red(msr), .lit_len(ms_len), .rises());
    led_panel ns_u (.mclk(mclk), .green(nsg), .red(nsr), .lit_len(ns_len), .rises());
    led_panel tr_u (.mclk(mclk), .green(traffic_led), .red(1'b0), .lit_len(tr_len),
        .rises(tr_rises));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic test_selftest;
        cyc(125 * CYC_MS);
        chk("st green", 16'h000A, {12'h000, msg, msr, nsg, nsr});
        cyc(250 * CYC_MS);
        chk("st red", 16'h0005, {12'h000, msg, msr, nsg, nsr});
        cyc(250 * CYC_MS);
        chk("st hold", 16'h0008, {12'h000, msg, msr, nsg, nsr});
        wr(4'h0, 8'h0C);
        cyc(10);
        chk("st flags", 16'h0008, {12'h000, msg, msr, nsg, nsr});
        $display("test selftest done");
    endtask

    // Lamp code: {green ever, green always, red ever, red always} over two samples
    task automatic check_mode(input logic [7:0] c, input logic [3:0] ms_c,
                              input logic [3:0] ns_c);
        logic [3:0] a;
        logic [3:0] b;
        wr(4'h0, c);
        cyc(10);
        a = {msg, msr, nsg, nsr};
        cyc(500 * CYC_MS);
        b = {msg, msr, nsg, nsr};
        chk("ms mode", {12'h000, ms_c}, {12'h000, a[3] | b[3], a[3] & b[3],
            a[2] | b[2], a[2] & b[2]});
        chk("ns mode", {12'h000, ns_c}, {12'h000, a[1] | b[1], a[1] & b[1],
            a[0] | b[0], a[0] & b[0]});
        if (ms_c == 4'h8 || ms_c == 4'h2 || ns_c == 4'h8 || ns_c == 4'h2)
        begin
            cyc(1000 * CYC_MS);
            if (ms_c == 4'h8 || ms_c == 4'h2)
                chk("ms flash len", 16'(500 * CYC_MS), ms_len);
            if (ns_c == 4'h8 || ns_c == 4'h2)
                chk("ns flash len", 16'(500 * CYC_MS), ns_len);
        end
    endtask

    task automatic test_modes;
        check_mode(8'h33, 4'hC, 4'hC);
        check_mode(8'h01, 4'h8, 4'h0);
        check_mode(8'h07, 4'h2, 4'h0);
        check_mode(8'h0F, 4'h3, 4'h0);
        check_mode(8'h13, 4'hC, 4'h8);
        check_mode(8'h73, 4'hC, 4'h2);
        check_mode(8'hF3, 4'hC, 4'h3);
        check_mode(8'h33, 4'hC, 4'hC);
        $display("test modes done");
    endtask

    task automatic test_regs;
        logic [7:0] d;
        rd(4'h0, d);
        chk("ctrl read", 16'h0033, {8'h00, d});
        rd(4'h4, d);
        chk("status read", 16'h0068, {8'h00, d});
        wr(4'h4, 8'hFF);
        wr(4'h8, 8'hFF);
        rd(4'h4, d);
        chk("status kept", 16'h0068, {8'h00, d});
        rd(4'h8, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
        rd(4'h0, d);
        chk("ctrl kept", 16'h0033, {8'h00, d});
        $display("test regs done");
    endtask

    task automatic test_link;
        @(posedge mclk);
        phy_link <= 1'b1;
        cyc(5);
        chk("link up", 16'h0001, {15'h0000, link_led});
        @(posedge mclk);
        phy_link <= 1'b0;
        cyc(4);
        chk("link down", 16'h0000, {15'h0000, link_led});
        $display("test link done");
    endtask

    task automatic pulse;
        @(posedge mclk);
        phy_activity <= 1'b1;
        repeat (4) @(posedge mclk);
        phy_activity <= 1'b0;
    endtask

    task automatic test_traffic;
        logic [7:0] r0;
        chk("traffic idle", 16'h0000, {15'h0000, traffic_led});
        pulse();
        cyc(250 * CYC_MS);
        chk("flicker len", 16'(50 * CYC_MS), tr_len);
        chk("traffic dark", 16'h0000, {15'h0000, traffic_led});
        r0 = tr_rises;
        repeat (40)
        begin
            pulse();
            cyc(10 * CYC_MS - 5);
        end
        cyc(150 * CYC_MS);
        chk("flicker rises", 16'h0005, {8'h00, tr_rises - r0});
        $display("test traffic done");
    endtask

    task automatic complete_run;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        test_selftest();
        test_modes();
        test_regs();
        test_link();
        test_traffic();
        complete_run();
    end

    initial
    begin
        repeat (90000) @(posedge mclk);
        err_total++;
        complete_run();
    end
endmodule
